/* cpls_ctrl.sv */
`timescale 1ns/1ps
// Behaviour
// R1: clock-stop request active enters stop-grant and issues stop-grant acknowledge.
// R2: stop-grant gates core clocks; bus unit and interrupt controller keep clocks.
// R3: in stop-grant, snooping and interrupt servicing stay enabled.
// R4: clock-stop release restarts all clocks and resumes execution.
// R5: clock-stop is asynchronous; bus clock is never affected by it.
// R6: sleep request in stop-grant moves the device into sleep.
// R7: sleep stops all unit clocks; only the pll keeps running.
// R8: sleeping device ignores snoops and interrupts.
// R9: sleeping device reacts only to sleep, clock-stop and reset; the code ignores clock-stop while in sleep.
// R10: sleep release returns to stop-grant, restarting bus and interrupt clocks.
// R11: system-management interrupt may arrive unrelated to any clock edge.
// R12: accepted management interrupt saves state and enters management mode.
// R13: in management mode issue SMI acknowledge, then start handler.
// R14: every async request passes two flip-flop stages before use.
// R15: sleep request outside stop-grant is ignored until stop-grant is entered.
module cpls_ctrl (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    // asynchronous requests from chipset
    input  wire logic                clock_stop_request_n,
    input  wire logic                sleep_request_n,
    input  wire logic                system_mgmt_interrupt_n,
    // acknowledge transactions to the bus unit
    output logic                     ack_valid,
    output cpls_pkg::cpls_ack_t      ack_code,
    input  wire logic                ack_ready,
    // clock gates
    output logic                     core_clk_en,
    output logic                     bus_clk_en,
    output logic                     lic_clk_en,
    output logic                     pll_en,
    // unit controls
    output logic                     snoop_en,
    output logic                     intr_en,
    output logic                     exec_en,
    output logic                     save_state,
    output logic                     handler_start,
    output logic                     system_mgmt_mode,
    output cpls_pkg::cpls_state_t    power_state
);
    logic stop_n;
    logic slp_n;
    logic smi_n;
    logic smi_prev_ff;
    logic smi_edge;
    logic smi_pend_ff;
    logic ack_req;
    cpls_pkg::cpls_ack_t ack_sel;
    cpls_pkg::cpls_state_t state_ff;
    cpls_pkg::cpls_state_t nxt_state;
    logic smm_ff;
    logic save_ff;
    logic start_ff;
    logic core_ff;
    logic buslic_ff;
    logic ack_wait_ff;

    // requests come in unclocked, so synchronise before any use
    cpls_sync u_sync_stop (.ref_clk(ref_clk), .rst_n(rst_n), // R5 R14
        .async_n(clock_stop_request_n), .sync_n(stop_n));
    cpls_sync u_sync_slp (.ref_clk(ref_clk), .rst_n(rst_n), // R14
        .async_n(sleep_request_n), .sync_n(slp_n));
    cpls_sync u_sync_smi (.ref_clk(ref_clk), .rst_n(rst_n), // R11 R14
        .async_n(system_mgmt_interrupt_n), .sync_n(smi_n));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            smi_prev_ff <= 1'b1;
        end else begin
            smi_prev_ff <= smi_n;
        end
    end
    assign smi_edge = smi_prev_ff & ~smi_n;

    // smi pending; sleep ignores it, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            smi_pend_ff <= 1'b0;
        end else if (smi_edge && state_ff != cpls_pkg::CPLS_SLEEP) begin
            smi_pend_ff <= 1'b1; // R9
        end else if (state_ff == cpls_pkg::CPLS_RUN && !smm_ff) begin
            smi_pend_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cpls_pkg::CPLS_RUN: begin
                if (smi_pend_ff && !smm_ff) begin
                    nxt_state = cpls_pkg::CPLS_SMM_ENTRY; // R12
                end else if (!stop_n) begin
                    nxt_state = cpls_pkg::CPLS_STOPGRANT; // R1
                end
            end
            cpls_pkg::CPLS_STOPGRANT: begin
                if (stop_n) begin
                    nxt_state = cpls_pkg::CPLS_RUN; // R4
                end else if (!slp_n) begin
                    nxt_state = cpls_pkg::CPLS_SLEEP; // R6 R15
                end
            end
            cpls_pkg::CPLS_SLEEP: begin
                if (slp_n) begin
                    nxt_state = cpls_pkg::CPLS_STOPGRANT; // R10
                end
            end
            cpls_pkg::CPLS_SMM_ENTRY: begin
                // wait for the smi acknowledge to be taken;
                // save_ff covers the cycle before ack_wait_ff is set
                if (!save_ff && !ack_wait_ff) begin
                    nxt_state = cpls_pkg::CPLS_RUN; // R13
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= cpls_pkg::CPLS_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // acknowledges are launched on state entry
    always_comb begin
        ack_req = 1'b0;
        ack_sel = cpls_pkg::CPLS_ACK_NONE;
        if (state_ff == cpls_pkg::CPLS_RUN && nxt_state == cpls_pkg::CPLS_STOPGRANT) begin
            ack_req = 1'b1; // R1
            ack_sel = cpls_pkg::CPLS_ACK_STOPGRANT;
        end else if (save_ff) begin
            ack_req = 1'b1; // R13
            ack_sel = cpls_pkg::CPLS_ACK_SMI;
        end
    end

    cpls_ack_issue u_ack (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .req       (ack_req),
        .code      (ack_sel),
        .ack_valid (ack_valid),
        .ack_code  (ack_code),
        .ack_ready (ack_ready)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_wait_ff <= 1'b0;
        end else if (save_ff) begin
            ack_wait_ff <= 1'b1;
        end else if (ack_ready && ack_valid) begin
            ack_wait_ff <= 1'b0;
        end
    end

    // save pulse on smm entry, handler start after ack
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            save_ff <= 1'b0;
        end else begin
            save_ff <= (state_ff == cpls_pkg::CPLS_RUN)
                     && (nxt_state == cpls_pkg::CPLS_SMM_ENTRY); // R12
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= (state_ff == cpls_pkg::CPLS_SMM_ENTRY)
                      && (nxt_state == cpls_pkg::CPLS_RUN); // R13
        end
    end

    // management mode held until reset; no resume path modelled
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            smm_ff <= 1'b0;
        end else if (save_ff) begin
            smm_ff <= 1'b1; // R12
        end
    end

    // clock gates registered so they never glitch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_ff   <= cpls_pkg::CPLS_GATE_RESET;
            buslic_ff <= cpls_pkg::CPLS_GATE_RESET;
        end else begin
            core_ff   <= (nxt_state == cpls_pkg::CPLS_RUN)
                       || (nxt_state == cpls_pkg::CPLS_SMM_ENTRY); // R2 R4
            buslic_ff <= (nxt_state != cpls_pkg::CPLS_SLEEP); // R7 R10
        end
    end

    assign core_clk_en      = core_ff;
    assign bus_clk_en       = buslic_ff;
    assign lic_clk_en       = buslic_ff;
    assign pll_en           = 1'b1; // R7
    assign snoop_en         = buslic_ff; // R3 R8
    assign intr_en          = buslic_ff; // R3 R8
    assign exec_en          = core_ff && state_ff == cpls_pkg::CPLS_RUN;
    assign save_state       = save_ff;
    assign handler_start    = start_ff;
    assign system_mgmt_mode = smm_ff;
    assign power_state      = state_ff;

    // checks
    sg_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        state_ff == cpls_pkg::CPLS_RUN && nxt_state == cpls_pkg::CPLS_STOPGRANT
        |=> ack_valid && ack_code == cpls_pkg::CPLS_ACK_STOPGRANT)
        else $error("stop-grant entry without acknowledge");
    sg_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
        $past(state_ff) == cpls_pkg::CPLS_STOPGRANT && state_ff == cpls_pkg::CPLS_STOPGRANT
        |-> !core_clk_en && bus_clk_en && lic_clk_en && snoop_en && intr_en)
        else $error("stop-grant clock gating wrong");
    sg_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        state_ff == cpls_pkg::CPLS_STOPGRANT && stop_n |=> core_clk_en && exec_en)
        else $error("clock-stop release did not resume");
    slp_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        state_ff == cpls_pkg::CPLS_STOPGRANT && !stop_n && !slp_n
        |=> state_ff == cpls_pkg::CPLS_SLEEP ##0 !bus_clk_en && !core_clk_en)
        else $error("sleep not entered");
    slp_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
        state_ff == cpls_pkg::CPLS_SLEEP && $past(state_ff) == cpls_pkg::CPLS_SLEEP
        |-> !snoop_en && !intr_en && pll_en)
        else $error("sleep left snoops or interrupts on");
    slp_exit_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
        state_ff == cpls_pkg::CPLS_SLEEP && slp_n
        |=> state_ff == cpls_pkg::CPLS_STOPGRANT && bus_clk_en && lic_clk_en)
        else $error("sleep exit wrong");
    slp_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R15
        state_ff == cpls_pkg::CPLS_RUN |=> state_ff != cpls_pkg::CPLS_SLEEP)
        else $error("sleep entered outside stop-grant");
    smi_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        save_ff |=> ack_valid && ack_code == cpls_pkg::CPLS_ACK_SMI && smm_ff)
        else $error("smi acknowledge missing");
    smi_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        $fell(system_mgmt_interrupt_n) ##1 !system_mgmt_interrupt_n |=> !smi_n)
        else $error("smi synchroniser depth wrong");
    stop_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        $fell(clock_stop_request_n) ##1 !clock_stop_request_n |=> !stop_n)
        else $error("clock-stop synchroniser depth wrong");
    slp_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
        $fell(sleep_request_n) ##1 !sleep_request_n |=> !slp_n)
        else $error("sleep synchroniser depth wrong");

    // management interrupt path and acknowledge hold
    smi_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        state_ff == cpls_pkg::CPLS_RUN && smi_pend_ff && !smm_ff
        |=> state_ff == cpls_pkg::CPLS_SMM_ENTRY && save_state)
        else $error("management interrupt not entered");
    smi_hdl_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        handler_start
        |-> !ack_valid && !ack_wait_ff && system_mgmt_mode)
        else $error("handler started before acknowledge taken");
    hdl_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
        handler_start
        |=> !handler_start)
        else $error("handler start longer than one cycle");
    smm_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
        system_mgmt_mode
        |=> system_mgmt_mode)
        else $error("management mode dropped before reset");
    ack_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1 R13
        ack_valid && !ack_ready && !ack_req |=> ack_valid && $stable(ack_code))
        else $error("acknowledge dropped before taken");

    // state and clock gate invariants
    slp_smi_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8 R9
        state_ff == cpls_pkg::CPLS_SLEEP && !smi_pend_ff
        |=> !smi_pend_ff)
        else $error("interrupt latched while sleeping");
    slp_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
        state_ff == cpls_pkg::CPLS_SLEEP
        |-> !core_clk_en && !bus_clk_en && !lic_clk_en && pll_en)
        else $error("clocks running in sleep");
    run_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        state_ff == cpls_pkg::CPLS_RUN
        |-> core_clk_en && bus_clk_en && lic_clk_en && snoop_en && intr_en)
        else $error("clocks gated while running");
    sg_snoop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        state_ff == cpls_pkg::CPLS_STOPGRANT
        |-> snoop_en && intr_en && !exec_en)
        else $error("stop-grant snoop or interrupt off");
    sg_bus_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        !stop_n && state_ff != cpls_pkg::CPLS_SLEEP |-> bus_clk_en && lic_clk_en)
        else $error("clock-stop touched the bus clock");

    sg_cov_c: cover property (@(posedge ref_clk) state_ff == cpls_pkg::CPLS_STOPGRANT);
    slp_cov_c: cover property (@(posedge ref_clk) state_ff == cpls_pkg::CPLS_SLEEP);
    smm_cov_c: cover property (@(posedge ref_clk) handler_start);
    ack_cov_c: cover property (@(posedge ref_clk) ack_valid && ack_ready);
    early_cov_c: cover property (@(posedge ref_clk) state_ff == cpls_pkg::CPLS_RUN && !slp_n);

endmodule : cpls_ctrl

/* cpls_pkg.sv */
package cpls_pkg;

    // power states, gray coded along run -> stop-grant -> sleep
    typedef enum logic [1:0] {
        CPLS_RUN       = 2'b00,
        CPLS_STOPGRANT = 2'b01,
        CPLS_SLEEP     = 2'b11,
        CPLS_SMM_ENTRY = 2'b10
    } cpls_state_t;

    // bus acknowledge transaction codes
    typedef enum logic [1:0] {
        CPLS_ACK_NONE      = 2'h0,
        CPLS_ACK_STOPGRANT = 2'h1,
        CPLS_ACK_SMI       = 2'h2
    } cpls_ack_t;

    localparam int unsigned CPLS_SYNC_STAGES = 2;
    localparam logic        CPLS_SYNC_RESET  = 1'b1;
    localparam logic        CPLS_GATE_RESET  = 1'b1;
    localparam logic [1:0]  CPLS_ACK_RESET   = 2'h0;

endpackage : cpls_pkg

/* cpls_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for an active-low asynchronous request
module cpls_sync (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // async in, synced out
    input  wire logic async_n,
    output logic      sync_n
);
    logic meta_ff;
    logic sync_ff;

    // first stage read only by the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_ff <= cpls_pkg::CPLS_SYNC_RESET;
            sync_ff <= cpls_pkg::CPLS_SYNC_RESET;
        end else begin
            meta_ff <= async_n;
            sync_ff <= meta_ff;
        end
    end

    assign sync_n = sync_ff;

endmodule : cpls_sync

/* cpls_ack_issue.sv */
`timescale 1ns/1ps
// holds an acknowledge request until the bus unit takes it
module cpls_ack_issue (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // request from the state machine
    input  wire logic             req,
    input  wire cpls_pkg::cpls_ack_t code,
    // bus side
    output logic                  ack_valid,
    output cpls_pkg::cpls_ack_t   ack_code,
    input  wire logic             ack_ready
);
    logic                pend_ff;
    cpls_pkg::cpls_ack_t code_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
        end else if (req) begin
            pend_ff <= 1'b1;
        end else if (ack_ready) begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            code_ff <= cpls_pkg::CPLS_ACK_NONE;
        end else if (req) begin
            code_ff <= code;
        end
    end

    assign ack_valid = pend_ff;
    assign ack_code  = code_ff;

endmodule : cpls_ack_issue

/* cpls_chipset.sv */
`timescale 1ns/1ps
// chipset side: request pins plus the bus unit that takes acknowledges
module cpls_chipset (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // commands from the bench
    input  wire logic want_stop,
    input  wire logic want_sleep,
    input  wire logic want_smi,
    input  wire logic slow_ack,
    // request pins
    output logic      clock_stop_request_n,
    output logic      sleep_request_n,
    output logic      system_mgmt_interrupt_n,
    // bus unit
    input  wire logic ack_valid,
    output logic      ack_ready
);
    logic [1:0] wait_ff;

    initial begin
        clock_stop_request_n    = 1'b1;
        sleep_request_n         = 1'b1;
        system_mgmt_interrupt_n = 1'b1;
        ack_ready               = 1'b0;
        wait_ff                 = 2'h0;
    end

    // skew off the edge: pins are unrelated to the bus clock
    always @(posedge ref_clk) begin
        clock_stop_request_n    <= #3 ~want_stop;
        sleep_request_n         <= #3 ~want_sleep;
        system_mgmt_interrupt_n <= #3 ~want_smi;
    end

    // slow bus unit keeps the ack waiting four cycles
    always @(posedge ref_clk) begin
        if (!rst_n || !ack_valid) begin
            wait_ff   <= 2'h0;
            ack_ready <= 1'b0;
        end else begin
            wait_ff   <= (wait_ff == 2'h3) ? wait_ff : wait_ff + 2'h1;
            ack_ready <= !slow_ack || wait_ff == 2'h3;
        end
    end
endmodule : cpls_chipset

/* cpls_ctrl_tb.sv */
`timescale 1ns/1ps
module cpls_ctrl_tb;
    logic                  ref_clk    = 1'b0;
    logic                  rst_n      = 1'b0;
    logic                  want_stop  = 1'b0;
    logic                  want_sleep = 1'b0;
    logic                  want_smi   = 1'b0;
    logic                  slow_ack   = 1'b1;
    logic                  clock_stop_request_n, sleep_request_n, system_mgmt_interrupt_n;
    logic                  ack_valid, ack_ready, core_clk_en, bus_clk_en, lic_clk_en;
    logic                  pll_en, snoop_en, intr_en, exec_en, save_state, handler_start;
    logic                  system_mgmt_mode;
    cpls_pkg::cpls_ack_t   ack_code;
    cpls_pkg::cpls_state_t power_state;
    int                    n_mismatch = 0;
    int                    n_compared = 0;
    int                    n_wait;

    always #12.5 ref_clk = ~ref_clk;

    cpls_chipset i_cpls_chipset (.ref_clk(ref_clk), .rst_n(rst_n), .want_stop(want_stop),
        .want_sleep(want_sleep), .want_smi(want_smi), .slow_ack(slow_ack),
        .clock_stop_request_n(clock_stop_request_n), .sleep_request_n(sleep_request_n),
        .system_mgmt_interrupt_n(system_mgmt_interrupt_n), .ack_valid(ack_valid),
        .ack_ready(ack_ready));

    cpls_ctrl i_cpls_ctrl (.ref_clk(ref_clk), .rst_n(rst_n),
        .clock_stop_request_n(clock_stop_request_n), .sleep_request_n(sleep_request_n),
        .system_mgmt_interrupt_n(system_mgmt_interrupt_n), .ack_valid(ack_valid),
        .ack_code(ack_code), .ack_ready(ack_ready), .core_clk_en(core_clk_en),
        .bus_clk_en(bus_clk_en), .lic_clk_en(lic_clk_en), .pll_en(pll_en),
        .snoop_en(snoop_en), .intr_en(intr_en), .exec_en(exec_en), .save_state(save_state),
        .handler_start(handler_start), .system_mgmt_mode(system_mgmt_mode),
        .power_state(power_state));

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // sample just after the edge so the design's updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wait_state(input cpls_pkg::cpls_state_t s);
        for (n_wait = 0; power_state !== s && n_wait < 20; n_wait++) step(1);
        chk("power_state", {2'h0, power_state}, {2'h0, s});
    endtask : wait_state

    task automatic chk_units(input logic [3:0] gates, input logic [3:0] units);
        chk("clock gates", {core_clk_en, bus_clk_en, lic_clk_en, pll_en}, gates);
        chk("unit enables", {1'b0, snoop_en, intr_en, exec_en}, units);
    endtask : chk_units

    task automatic leave_low;
        @(posedge ref_clk) want_sleep <= 1'b0;
        step(1);
        wait_state(cpls_pkg::CPLS_STOPGRANT);
        chk_units(4'h7, 4'h6);
        @(posedge ref_clk) want_stop <= 1'b0;
        step(1);
        wait_state(cpls_pkg::CPLS_RUN);
        chk_units(4'hf, 4'h7);
    endtask : leave_low

    task automatic t_reset;
        wait_state(cpls_pkg::CPLS_RUN);
        chk_units(4'hf, 4'h7);
        chk("ack_valid", {3'h0, ack_valid}, 4'h0);
        chk("system_mgmt_mode", {3'h0, system_mgmt_mode}, 4'h0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_stopgrant;
        @(posedge ref_clk) want_stop <= 1'b1;
        step(1);
        wait_state(cpls_pkg::CPLS_STOPGRANT);
        chk("sync depth", {3'h0, n_wait >= 2}, 4'h1);
        chk("ack_valid", {3'h0, ack_valid}, 4'h1);
        chk("ack_code", {2'h0, ack_code}, {2'h0, cpls_pkg::CPLS_ACK_STOPGRANT});
        chk_units(4'h7, 4'h6);
        step(2);
        chk("ack held", {3'h0, ack_valid}, 4'h1);
        for (n_wait = 0; ack_valid !== 1'b0 && n_wait < 10; n_wait++) step(1);
        chk("ack taken", {3'h0, ack_valid}, 4'h0);
        $display("t_stopgrant done");
    endtask : t_stopgrant

    task automatic t_sleep;
        @(posedge ref_clk) want_sleep <= 1'b1;
        step(1);
        wait_state(cpls_pkg::CPLS_SLEEP);
        chk_units(4'h1, 4'h0);
        @(posedge ref_clk) want_smi <= 1'b1;
        step(3);
        @(posedge ref_clk) want_smi <= 1'b0;
        step(6);
        chk("state kept", {2'h0, power_state}, {2'h0, cpls_pkg::CPLS_SLEEP});
        chk("smi ignored", {2'h0, ack_valid, system_mgmt_mode}, 4'h0);
        leave_low();
        $display("t_sleep done");
    endtask : t_sleep

    task automatic t_early_sleep;
        @(posedge ref_clk) want_sleep <= 1'b1;
        step(8);
        chk("early sleep", {2'h0, power_state}, {2'h0, cpls_pkg::CPLS_RUN});
        chk_units(4'hf, 4'h7);
        @(posedge ref_clk) want_stop <= 1'b1;
        step(1);
        wait_state(cpls_pkg::CPLS_STOPGRANT);
        wait_state(cpls_pkg::CPLS_SLEEP);
        leave_low();
        $display("t_early_sleep done");
    endtask : t_early_sleep

    task automatic t_smi;
        @(posedge ref_clk) want_smi <= 1'b1;
        slow_ack <= 1'b0;
        step(1);
        for (n_wait = 0; save_state !== 1'b1 && n_wait < 10; n_wait++) step(1);
        chk("save_state", {3'h0, save_state}, 4'h1);
        chk("mode after save", {3'h0, system_mgmt_mode}, 4'h0);
        for (n_wait = 0; ack_valid !== 1'b1 && n_wait < 10; n_wait++) step(1);
        chk("ack_code", {2'h0, ack_code}, {2'h0, cpls_pkg::CPLS_ACK_SMI});
        chk("system_mgmt_mode", {3'h0, system_mgmt_mode}, 4'h1);
        for (n_wait = 0; handler_start !== 1'b1 && n_wait < 10; n_wait++) step(1);
        chk("handler_start", {3'h0, handler_start}, 4'h1);
        chk("ack before handler", {3'h0, ack_valid}, 4'h0);
        step(1);
        chk("handler pulse", {2'h0, handler_start, system_mgmt_mode}, 4'h1);
        @(posedge ref_clk) want_smi <= 1'b0;
        $display("t_smi done");
    endtask : t_smi

    task automatic t_sleep_reset;
        @(posedge ref_clk) want_stop <= 1'b1;
        want_sleep <= 1'b1;
        step(1);
        wait_state(cpls_pkg::CPLS_SLEEP);
        @(posedge ref_clk) rst_n <= 1'b0;
        want_stop  <= 1'b0;
        want_sleep <= 1'b0;
        step(3);
        chk("reset wakes", {2'h0, power_state}, {2'h0, cpls_pkg::CPLS_RUN});
        chk_units(4'hf, 4'h7);
        chk("mode cleared", {3'h0, system_mgmt_mode}, 4'h0);
        @(posedge ref_clk) rst_n <= 1'b1;
        step(4);
        chk("after reset", {2'h0, power_state}, {2'h0, cpls_pkg::CPLS_RUN});
        chk_units(4'hf, 4'h7);
        $display("t_sleep_reset done");
    endtask : t_sleep_reset

    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        step(1);
        t_reset();
        t_stopgrant();
        t_sleep();
        t_early_sleep();
        t_smi();
        t_sleep_reset();
        final_report();
    end

    // the whole run needs roughly a hundred cycles
    initial begin
        #(25.0 * 3000);
        n_mismatch++;
        final_report();
    end
endmodule : cpls_ctrl_tb
